// ===== ctsa_addr_decode.sv
`include "ctsa_consts.svh"

module ctsa_addr_decode (
    // Request address
    input  wire logic [31:0] index_group,
    input  wire logic [31:0] index_offset,
    // Decoded fields
    output logic             is_coupler,
    output logic [15:0]      table_num,
    output logic [15:0]      reg_num,
    output logic [1:0]       chan,
    output logic             chan_valid,
    output logic             tbl_known,
    output logic             tbl_scan,
    output logic             tbl_ro,
    output logic [2:0]       tbl_slot,
    output logic             reg_in_range
);

    assign is_coupler   = (index_group == 32'h0000_0000);
    assign table_num    = index_offset[31:16];
    assign reg_num      = index_offset[15:0];
    assign chan         = index_offset[17:16];
    assign chan_valid   = (index_offset[31:16] <= `CTSA_MAX_CHAN);
    assign tbl_scan     = (table_num == 16'h0009);
    assign tbl_ro       = tbl_scan || (table_num == 16'h005A) || (table_num == 16'h007F);
    assign reg_in_range = (reg_num < {8'h00, `CTSA_TBL_LEN});

    // Only tables 0, 9, 90, 98, 99, 100, 127 exist
    assign tbl_known = (table_num == 16'h0000) || tbl_scan ||
                       (table_num == 16'h005A) || (table_num == 16'h0062) ||
                       (table_num == 16'h0063) || (table_num == 16'h0064) ||
                       (table_num == 16'h007F);

    assign tbl_slot = (table_num == 16'h0062) ? 3'h1 :
                      (table_num == 16'h0063) ? 3'h2 :
                      (table_num == 16'h0064) ? 3'h3 :
                      (table_num == 16'h005A) ? 3'h4 :
                      (table_num == 16'h007F) ? 3'h5 : 3'h0;

endmodule

// ===== ctsa_consts.svh
`ifndef CTSA_CONSTS_SVH
`define CTSA_CONSTS_SVH

// Register byte offsets
`define CTSA_OFF_CTRL       8'h00
`define CTSA_OFF_STATUS     8'h04
`define CTSA_OFF_IRQ_STAT   8'h08
`define CTSA_OFF_IRQ_MASK   8'h0C
`define CTSA_OFF_GROUP      8'h10
`define CTSA_OFF_OFFSET     8'h14
`define CTSA_OFF_WDATA      8'h18
`define CTSA_OFF_CMD        8'h1C
`define CTSA_OFF_RESULT     8'h20

// Control and status word bits
`define CTSA_BIT_BUS_ERR    0
`define CTSA_BIT_CFG_ERR    1
`define CTSA_BIT_OUT_DIS    4
`define CTSA_BIT_OVERRUN    5
`define CTSA_CTRL_MASK      16'h0030
`define CTSA_CTRL_RST       16'h0000

// Interrupt bits
`define CTSA_IRQ_DONE       0
`define CTSA_IRQ_FAIL       1
`define CTSA_IRQ_OVERRUN    2
`define CTSA_IRQ_SCAN       3

// Command and result bits
`define CTSA_CMD_GO         0
`define CTSA_CMD_WRITE      1
`define CTSA_RES_BUSY       0
`define CTSA_RES_DONE       1
`define CTSA_RES_ABORT      2
`define CTSA_RES_ERROR      3
`define CTSA_RES_UPPER      4

// Tables
`define CTSA_TBL_LEN        8'h80
`define CTSA_LOWER_DEVICES  7'h3F
`define CTSA_MAX_CHAN       16'h0003
`define CTSA_SERVICE_PORT   16'h0064
`define CTSA_COUPLER_ID     16'h1234

`endif

// ===== ctsa_pkg.sv
package ctsa_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TABLE,
        ST_TERM,
        ST_FINISH
    } ctsa_state_t;

    typedef logic [15:0] ctsa_word_t;

endpackage

// ===== ctsa_scan_table.sv
`include "ctsa_consts.svh"

module ctsa_scan_table (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Terminal scan report
    input  wire logic        scan_entry_valid,
    input  wire logic        scan_complex,
    input  wire logic [14:0] scan_type_num,
    input  wire logic [6:0]  scan_pd_bits,
    input  wire logic [5:0]  scan_ext,
    input  wire logic        scan_special,
    input  wire logic        scan_output,
    input  wire logic        scan_end,
    // Read port
    input  wire logic [6:0]  rd_entry,
    output logic [15:0]      rd_data,
    output logic [6:0]       term_count,
    output logic             scan_frozen
);

    logic [15:0] entry_mem [0:127];
    logic [6:0]  count_r;
    logic        frozen_r;
    logic [15:0] code_word;
    logic        take;

    // Complex: bit 15 clear, type number; simple: bit 15 set, packed fields
    assign code_word = scan_complex ? {1'b0, scan_type_num}
                                    : {1'b1, scan_pd_bits, scan_ext,
                                       scan_special, scan_output};
    assign take = scan_entry_valid && !frozen_r && (count_r < 7'h7E);

    // Table reflects power-up scan only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_r  <= 7'h00;
            frozen_r <= 1'b0;
        end else begin
            if (take) begin
                count_r <= count_r + 7'h01;
            end
            if (scan_end) begin
                frozen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (take) begin
            entry_mem[count_r + 7'h02] <= code_word;
        end
    end

    assign rd_data = (rd_entry == 7'h00) ? {9'h000, count_r} :
                     (rd_entry == 7'h01) ? `CTSA_COUPLER_ID :
                     entry_mem[rd_entry];
    assign term_count  = count_r;
    assign scan_frozen = frozen_r;

endmodule

// ===== ctsa_term_model.sv
module ctsa_term_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Engine request side
    input  wire logic        term_req,
    input  wire logic [15:0] term_num,
    input  wire logic [1:0]  term_chan,
    input  wire logic [15:0] term_reg,
    // Bench knobs
    input  wire logic [3:0]  dly,
    input  wire logic        fail,
    // Engine answer side
    output logic             term_ack,
    output logic             term_abort,
    output logic [15:0]      term_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    // Answers once per request after dly cycles; data line toggles when idle
    always_ff @(posedge clk_sys) begin
        term_ack <= 1'b0;
        term_abort <= 1'b0;
        term_rdata <= ~term_rdata;
        if (rst || !term_req) begin
            cnt_r <= 5'h00;
            if (rst) begin
                term_rdata <= 16'h5A5A;
            end
        end else if (cnt_r == {1'b0, dly}) begin
            term_ack <= !fail;
            term_abort <= fail;
            term_rdata <= {term_num[3:0], 2'h0, term_chan, term_reg[7:0]};
            cnt_r <= 5'h1F;
        end else if (cnt_r != 5'h1F) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule

// ===== ctsa_top.sv
// Functional notes
// - Port 100; group zero coupler, else terminal
// - Coupler offset: high table, low register
// - Terminal offset: high channel, low register
// - Only tables 0,9,90,98,99,100,127 exist
// - Table 9 frozen after power-up scan
// - First 63 devices lower object, rest upper
// - Entry 1 coupler id, terminals from 2
// - Entry 0 counts terminals incl. end terminal
// - Type word bit 15 selects terminal kind
// - Complex: bit15 clear, register 8 type number
// - Simple: bit15 set, packed size and flags
// - Status: 0 ok, bit0 bus, bit1 config
// - Status bit4 outputs off, bit5 overrun
// - Control bit4 disables all terminal outputs
// - Control bit5 enables overrun reporting
// - Channel index above 3 is invalid
// - Missing or non-register terminal gives abort
//
// Chosen here: the placing of the registers and the APB slave port.
`include "ctsa_consts.svh"

module ctsa_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Terminal bus condition
    input  wire logic        term_bus_err,
    input  wire logic        term_cfg_err,
    input  wire logic        term_overrun,
    output logic             outputs_disable,
    // Scan report
    input  wire logic        scan_entry_valid,
    input  wire logic        scan_complex,
    input  wire logic [14:0] scan_type_num,
    input  wire logic [6:0]  scan_pd_bits,
    input  wire logic [5:0]  scan_ext,
    input  wire logic        scan_special,
    input  wire logic        scan_output,
    input  wire logic        scan_end,
    // Terminal register engine
    output logic             term_req,
    output logic             term_wr,
    output logic [15:0]      term_num,
    output logic [1:0]       term_chan,
    output logic [15:0]      term_reg,
    output logic [15:0]      term_wdata,
    input  wire logic        term_ack,
    input  wire logic        term_abort,
    input  wire logic [15:0] term_rdata
);

    ctsa_pkg::ctsa_state_t state_r;
    ctsa_pkg::ctsa_state_t state_nxt;

    logic [15:0] ctrl_r;
    logic        overrun_r;
    logic [3:0]  irq_stat_r;
    logic [3:0]  irq_mask_r;
    logic [31:0] group_r;
    logic [31:0] offset_r;
    logic [15:0] wdata_r;
    logic        req_wr_r;
    logic        done_r;
    logic        abort_r;
    logic        error_r;
    logic        upper_r;
    logic [15:0] rdata_r;
    logic        scan_end_seen_r;
    logic [15:0] tbl_mem [0:767];

    // Decoder and scan table outputs
    logic        is_coupler;
    logic [15:0] table_num;
    logic [15:0] reg_num;
    logic [1:0]  chan;
    logic        chan_valid;
    logic        tbl_known;
    logic        tbl_scan;
    logic        tbl_ro;
    logic [2:0]  tbl_slot;
    logic        reg_in_range;
    logic [15:0] scan_rd;
    logic [6:0]  term_count;
    logic        scan_frozen;

    ctsa_addr_decode u_dec (
        .index_group  (group_r),
        .index_offset (offset_r),
        .is_coupler   (is_coupler),
        .table_num    (table_num),
        .reg_num      (reg_num),
        .chan         (chan),
        .chan_valid   (chan_valid),
        .tbl_known    (tbl_known),
        .tbl_scan     (tbl_scan),
        .tbl_ro       (tbl_ro),
        .tbl_slot     (tbl_slot),
        .reg_in_range (reg_in_range)
    );

    ctsa_scan_table u_scan (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .scan_entry_valid (scan_entry_valid),
        .scan_complex     (scan_complex),
        .scan_type_num    (scan_type_num),
        .scan_pd_bits     (scan_pd_bits),
        .scan_ext         (scan_ext),
        .scan_special     (scan_special),
        .scan_output      (scan_output),
        .scan_end         (scan_end),
        .rd_entry         (reg_num[6:0]),
        .rd_data          (scan_rd),
        .term_count       (term_count),
        .scan_frozen      (scan_frozen)
    );

    // APB decode
    wire        apb_acc   = psel && penable && pready;
    wire        apb_wr    = apb_acc && pwrite;
    wire        busy      = (state_r != ctsa_pkg::ST_IDLE);
    wire        sel_ctrl  = (paddr == `CTSA_OFF_CTRL);
    wire        sel_stat  = (paddr == `CTSA_OFF_STATUS);
    wire        sel_istat = (paddr == `CTSA_OFF_IRQ_STAT);
    wire        sel_imask = (paddr == `CTSA_OFF_IRQ_MASK);
    wire        sel_grp   = (paddr == `CTSA_OFF_GROUP);
    wire        sel_off   = (paddr == `CTSA_OFF_OFFSET);
    wire        sel_wdat  = (paddr == `CTSA_OFF_WDATA);
    wire        sel_cmd   = (paddr == `CTSA_OFF_CMD);
    wire        sel_res   = (paddr == `CTSA_OFF_RESULT);
    wire        sel_any   = sel_ctrl | sel_stat | sel_istat | sel_imask | sel_grp |
                            sel_off | sel_wdat | sel_cmd | sel_res;
    wire        wr_busy   = busy && (sel_grp | sel_off | sel_wdat | sel_cmd);
    wire        bad_acc   = !sel_any || (pwrite && (sel_stat || sel_res)) || (pwrite && wr_busy);
    wire        wr_ok     = apb_wr && !bad_acc;
    wire        start     = wr_ok && sel_cmd && pwdata[`CTSA_CMD_GO];

    // Status word assembled from conditions, unassigned bits zero
    wire [15:0] status_word = {10'h000, overrun_r && ctrl_r[`CTSA_BIT_OVERRUN],
                               ctrl_r[`CTSA_BIT_OUT_DIS], 2'b00,
                               term_cfg_err, term_bus_err};
    wire [31:0] result_word = {rdata_r, 11'h000, upper_r, error_r, abort_r, done_r, busy};

    wire [31:0] rd_mux = sel_ctrl  ? {16'h0000, ctrl_r} :
                         sel_stat  ? {16'h0000, status_word} :
                         sel_istat ? {28'h0000000, irq_stat_r} :
                         sel_imask ? {28'h0000000, irq_mask_r} :
                         sel_grp   ? group_r :
                         sel_off   ? offset_r :
                         sel_wdat  ? {16'h0000, wdata_r} :
                         sel_res   ? result_word : 32'h0000_0000;

    // Request classification
    wire [9:0]  tbl_addr  = {tbl_slot, reg_num[6:0]};
    wire        coup_err  = !tbl_known || !reg_in_range || (req_wr_r && tbl_ro);
    wire        term_miss = (group_r > {25'h0000000, term_count});
    wire        fin_tbl   = (state_r == ctsa_pkg::ST_TABLE);
    wire        fin_term  = (state_r == ctsa_pkg::ST_TERM) && (term_ack || term_abort);
    wire        ev_done   = fin_tbl || fin_term;
    wire        ev_fail   = (fin_tbl && coup_err) || (fin_term && term_abort);
    wire        ev_scan   = scan_end && !scan_end_seen_r;
    wire [3:0]  events    = {ev_scan, term_overrun, ev_fail, ev_done};
    wire [3:0]  w1c       = (wr_ok && sel_istat) ? pwdata[3:0] : 4'h0;
    wire [3:0]  mask_nxt  = (wr_ok && sel_imask) ? pwdata[3:0] : irq_mask_r;

    // Request sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ctsa_pkg::ST_IDLE: begin
                if (start) begin
                    state_nxt = ctsa_pkg::ST_TABLE;
                end
            end
            ctsa_pkg::ST_TABLE: begin
                if (!is_coupler && chan_valid && !term_miss) begin
                    state_nxt = ctsa_pkg::ST_TERM;
                end else begin
                    state_nxt = ctsa_pkg::ST_FINISH;
                end
            end
            ctsa_pkg::ST_TERM: begin
                if (term_ack || term_abort) begin
                    state_nxt = ctsa_pkg::ST_FINISH;
                end
            end
            ctsa_pkg::ST_FINISH: begin
                state_nxt = ctsa_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = ctsa_pkg::ST_IDLE;
            end
        endcase
    end

    // APB response, one wait state per access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && bad_acc;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r     <= `CTSA_CTRL_RST;
            irq_mask_r <= 4'h0;
            group_r    <= 32'h0000_0000;
            offset_r   <= 32'h0000_0000;
            wdata_r    <= 16'h0000;
        end else if (wr_ok) begin
            if (sel_ctrl) begin
                ctrl_r <= pwdata[15:0] & `CTSA_CTRL_MASK;
            end
            if (sel_imask) begin
                irq_mask_r <= pwdata[3:0];
            end
            if (sel_grp) begin
                group_r <= pwdata;
            end
            if (sel_off) begin
                offset_r <= pwdata;
            end
            if (sel_wdat) begin
                wdata_r <= pwdata[15:0];
            end
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_stat_r      <= 4'h0;
            overrun_r       <= 1'b0;
            scan_end_seen_r <= 1'b0;
            irq             <= 1'b0;
            outputs_disable <= 1'b0;
        end else begin
            irq_stat_r      <= (irq_stat_r & ~w1c) | events;
            overrun_r       <= term_overrun || (overrun_r && ctrl_r[`CTSA_BIT_OVERRUN]);
            scan_end_seen_r <= scan_end_seen_r || scan_end;
            irq             <= |(((irq_stat_r & ~w1c) | events) & mask_nxt);
            outputs_disable <= ctrl_r[`CTSA_BIT_OUT_DIS];
        end
    end

    // Request state and results
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r  <= ctsa_pkg::ST_IDLE;
            req_wr_r <= 1'b0;
            done_r   <= 1'b0;
            abort_r  <= 1'b0;
            error_r  <= 1'b0;
            upper_r  <= 1'b0;
            rdata_r  <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (start) begin
                req_wr_r <= pwdata[`CTSA_CMD_WRITE];
                done_r   <= 1'b0;
                abort_r  <= 1'b0;
                error_r  <= 1'b0;
                upper_r  <= 1'b0;
            end
            if (fin_tbl && is_coupler) begin
                done_r  <= 1'b1;
                error_r <= coup_err;
                rdata_r <= (coup_err | req_wr_r) ? 16'h0 : tbl_scan ? scan_rd : tbl_mem[tbl_addr];
                upper_r <= tbl_scan && (reg_num[6:0] > `CTSA_LOWER_DEVICES);
            end
            if (fin_tbl && !is_coupler && (!chan_valid || term_miss)) begin
                done_r  <= 1'b1;
                error_r <= !chan_valid;
                abort_r <= chan_valid;
            end
            if (fin_term) begin
                done_r  <= 1'b1;
                abort_r <= term_abort;
                rdata_r <= term_abort ? 16'h0000 : term_rdata;
            end
        end
    end

    // Writable coupler tables
    always_ff @(posedge clk_sys) begin
        if (fin_tbl && is_coupler && req_wr_r && !coup_err) begin
            tbl_mem[tbl_addr] <= wdata_r;
        end
    end

    // Terminal register engine request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            term_req   <= 1'b0;
            term_wr    <= 1'b0;
            term_num   <= 16'h0000;
            term_chan  <= 2'b00;
            term_reg   <= 16'h0000;
            term_wdata <= 16'h0000;
        end else begin
            term_req <= (state_nxt == ctsa_pkg::ST_TERM);
            if (fin_tbl) begin
                term_wr    <= req_wr_r;
                term_num   <= group_r[15:0];
                term_chan  <= chan;
                term_reg   <= reg_num;
                term_wdata <= wdata_r;
            end
        end
    end

    // Checks
    a_ctrl_outdis: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_r[`CTSA_BIT_OUT_DIS] |=> outputs_disable) else $error("outputs not disabled");
    a_status_zero: assert property (@(posedge clk_sys) disable iff (rst)
        status_word[15:6] == 10'h000 && status_word[3:2] == 2'b00)
        else $error("unassigned status bit set");
    a_overrun_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl_r[`CTSA_BIT_OVERRUN] |-> !status_word[5]) else $error("overrun shown while off");
    a_bad_chan: assert property (@(posedge clk_sys) disable iff (rst)
        fin_tbl && !is_coupler && !chan_valid |=> done_r && error_r && !term_req)
        else $error("invalid channel not refused");
    a_term_miss: assert property (@(posedge clk_sys) disable iff (rst)
        fin_tbl && !is_coupler && chan_valid && term_miss |=> abort_r ##1 !busy)
        else $error("missing terminal not aborted");
    a_unknown_tbl: assert property (@(posedge clk_sys) disable iff (rst)
        fin_tbl && is_coupler && !tbl_known |=> error_r && rdata_r == 16'h0000)
        else $error("unknown table not refused");
    a_scan_frozen: assert property (@(posedge clk_sys) disable iff (rst)
        scan_frozen |=> $stable(term_count)) else $error("scan table changed after scan");
    a_term_route: assert property (@(posedge clk_sys) disable iff (rst)
        term_req |-> term_chan == offset_r[17:16] && term_reg == offset_r[15:0])
        else $error("terminal address mis-split");
    a_count_step: assert property (@(posedge clk_sys) disable iff (rst)
        scan_entry_valid && !scan_frozen && term_count < 7'h7E |=>
        term_count == $past(term_count) + 7'h01) else $error("terminal count wrong");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        |(irq_stat_r & irq_mask_r) |-> irq) else $error("interrupt missing");

    c_coupler_read: cover property (@(posedge clk_sys) disable iff (rst)
        fin_tbl && is_coupler && !coup_err && !req_wr_r);
    c_term_ok: cover property (@(posedge clk_sys) disable iff (rst) fin_term && term_ack);
    c_term_abort: cover property (@(posedge clk_sys) disable iff (rst) fin_term && term_abort);
    c_outdis: cover property (@(posedge clk_sys) disable iff (rst) $rose(outputs_disable));

endmodule

// ===== testbench.sv
`include "ctsa_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RM = 32'hFFFF_FFFC;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, fail, term_wr;
    logic        term_bus_err, term_cfg_err, term_overrun, outputs_disable, scan_end;
    logic        scan_entry_valid, scan_complex, scan_special, scan_output;
    logic        term_req, term_ack, term_abort;
    logic [1:0]  term_chan;
    logic [3:0]  dly;
    logic [5:0]  scan_ext;
    logic [6:0]  scan_pd_bits;
    logic [7:0]  paddr;
    logic [14:0] scan_type_num;
    logic [15:0] term_num, term_reg, term_wdata, term_rdata;
    logic [31:0] pwdata, prdata, rd, r;
    logic [31:0] seed = 32'h0000_0056;
    logic [64:0] exp_q[$];
    int          num_errors = 0;
    int          num_checks = 0;
    ctsa_top ctsa_top_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .term_bus_err, .term_cfg_err, .term_overrun, .outputs_disable,
        .scan_entry_valid, .scan_complex, .scan_type_num, .scan_pd_bits, .scan_ext,
        .scan_special, .scan_output, .scan_end, .term_req, .term_wr, .term_num, .term_chan,
        .term_reg, .term_wdata, .term_ack, .term_abort, .term_rdata);
    ctsa_term_model ctsa_term_model_i (.clk_sys, .rst, .term_req, .term_num, .term_chan,
        .term_reg, .dly, .fail, .term_ack, .term_abort, .term_rdata);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] res(input logic [15:0] d, input logic er, input logic ab);
        return {d, 12'h000, er, ab, 2'h0};
    endfunction
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic er);
        int n;
        exp_q.push_back({er, m, e});
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic req(input logic [31:0] g, input logic [31:0] o, input logic [1:0] c,
                       input logic [31:0] m, input logic [31:0] e);
        int n;
        apb(1'b1, `CTSA_OFF_GROUP, g, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `CTSA_OFF_OFFSET, o, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `CTSA_OFF_CMD, {30'h0, c}, 32'h0, 32'h0, 1'b0);
        n = 0;
        do begin
            apb(1'b0, `CTSA_OFF_RESULT, 32'h0, 32'h0, 32'h0, 1'b0);
            n++;
        end while (rd[0] !== 1'b0 && n < 60);
        if (n >= 60) begin
            num_errors++;
            wrap_up();
        end
        apb(1'b0, `CTSA_OFF_RESULT, 32'h0, m, e, 1'b0);
    endtask
    task automatic sc(input logic cx, input logic [14:0] t, input logic [6:0] pd);
        @(posedge clk_sys);
        scan_entry_valid <= 1'b1;
        scan_complex <= cx;
        scan_type_num <= t;
        scan_pd_bits <= pd;
        @(posedge clk_sys);
        scan_entry_valid <= 1'b0;
    endtask
    // Result checker fed by the queue of expectations
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk("prdata", prdata & exp_q[0][63:32], exp_q[0][31:0]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, exp_q[0][64]});
            void'(exp_q.pop_front());
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        logic [15:0] e9[5] = '{16'h0003, `CTSA_COUPLER_ID, 16'h0CF2, 16'h8817, 16'h2332};
        logic [15:0] tw[4] = '{16'h0000, 16'h0062, 16'h0063, 16'h0064};
        logic [15:0] tb[5] = '{16'h0001, 16'h000A, 16'h005B, 16'h0065, 16'h007E};
        {rst, psel, penable, pwrite, paddr, pwdata, term_bus_err, term_cfg_err, fail, dly} = '0;
        {term_overrun, scan_entry_valid, scan_complex, scan_type_num, scan_pd_bits, scan_end} = '0;
        {scan_ext, scan_special, scan_output} = {6'h05, 1'b1, 1'b1};
        rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, `CTSA_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(1'b0, `CTSA_OFF_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(1'b0, 8'h24, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b1, `CTSA_OFF_STATUS, 32'h1, 32'h0, 32'h0, 1'b1);
        sc(1'b1, 15'h0CF2, 7'h00);
        sc(1'b0, 15'h0000, 7'h08);
        sc(1'b1, 15'h2332, 7'h00);
        @(posedge clk_sys);
        scan_end <= 1'b1;
        @(posedge clk_sys);
        scan_end <= 1'b0;
        sc(1'b1, 15'h7FFF, 7'h00);
        apb(1'b0, `CTSA_OFF_IRQ_STAT, 32'h0, 32'hFFFF_FFFF, 32'h8, 1'b0);
        apb(1'b1, `CTSA_OFF_IRQ_STAT, 32'hF, 32'h0, 32'h0, 1'b0);
        foreach (e9[i]) req(0, {16'h9, 16'(i)}, 2'b01, RM, res(e9[i], 0, 0));
        req(0, {16'h9, 16'h003F}, 2'b01, 32'h10, 32'h0);
        req(0, {16'h9, 16'h0040}, 2'b01, 32'h10, 32'h10);
        apb(1'b1, `CTSA_OFF_CTRL, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `CTSA_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h30, 1'b0);
        chk("outputs_disable", {31'h0, outputs_disable}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            {term_cfg_err, term_bus_err} <= r[1:0];
            dly <= r[7:4];
            apb(1'b0, `CTSA_OFF_STATUS, 32'h0, 32'hFFFF_FFFF, {28'h1, 2'h0, r[1:0]}, 1'b0);
        end
        {term_bus_err, term_cfg_err} <= 2'b00;
        apb(1'b1, `CTSA_OFF_IRQ_MASK, 32'h4, 32'h0, 32'h0, 1'b0);
        term_overrun <= 1'b1;
        @(posedge clk_sys);
        term_overrun <= 1'b0;
        apb(1'b0, `CTSA_OFF_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h30, 1'b0);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, `CTSA_OFF_IRQ_STAT, 32'h4, 32'h0, 32'h0, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `CTSA_OFF_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
        term_overrun <= 1'b1;
        @(posedge clk_sys);
        term_overrun <= 1'b0;
        apb(1'b0, `CTSA_OFF_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
        chk("outputs_disable", {31'h0, outputs_disable}, 32'h0);
        foreach (tw[i]) begin
            apb(1'b1, `CTSA_OFF_WDATA, {16'h0, 16'hA5C0 ^ tw[i]}, 32'h0, 32'h0, 1'b0);
            req(0, {tw[i], 16'h0003}, 2'b11, RM, 32'h0);
            req(0, {tw[i], 16'h0003}, 2'b01, RM, res(16'hA5C0 ^ tw[i], 0, 0));
        end
        foreach (tb[i]) req(0, {tb[i], 16'h0}, 2'b01, RM, res(0, 1, 0));
        req(0, {16'h005A, 16'h0}, 2'b01, 32'hC, 32'h0);
        req(0, {16'h007F, 16'h0}, 2'b01, 32'hC, 32'h0);
        req(0, {16'h0063, 16'h0080}, 2'b01, RM, res(0, 1, 0));
        req(0, {16'h0009, 16'h0002}, 2'b11, RM, res(0, 1, 0));
        req(2, {16'h1, 16'h1F}, 2'b01, RM, res(16'h211F, 0, 0));
        req(2, {16'h1, 16'h1F}, 2'b11, RM, res(16'h211F, 0, 0));
        chk("term_wdata", {15'h0, term_wr, term_wdata}, {15'h0, 1'b1, 16'hA5A4});
        req(2, {16'h4, 16'h1F}, 2'b01, 32'hC, 32'h8);
        req(4, {16'h0, 16'h1}, 2'b01, 32'hC, 32'h4);
        fail <= 1'b1;
        req(3, {16'h3, 16'h8}, 2'b01, 32'hC, 32'h4);
        wrap_up();
    end
endmodule
